// ### verilog/cssao_top.sv
// Clock source select, boot clock setup and debug clock output with APB registers
//
// Overview of operation
// RULE1: Debug clock pin carries the internal clock chosen by the source-select field.
// RULE2: Clock-off bit disables the debug clock pin; disabled means high impedance.
// RULE3: Pin driven after reset; boot start sets clock-off to one.
// RULE4: Strap low: 32 kHz oscillator feeds timer and generator; external clock ignored.
// RULE5: Strap high: external clock feeds generator; oscillator feeds only the timer.
// RULE6: Board holds the strap fixed; it never changes during operation.
// RULE7: External clock selected: boot bypasses PLL, assuming 11.2896, 12 or 12.288 MHz.
// RULE8: Boot sets serial interface clock to 500 kHz, two-wire clock to 400 kHz. Code loads the dividers only with strap high; strap low leaves both at 1.
`timescale 1ns/1ps
module cssao_top
   import cssao_pkg::*;
#(
   parameter int BOOT_REF_HZ = BOOT_REF_12M_HZ
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire cssao_apb_req_type apb_req,
   output logic [DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire cssao_clk_in_type clk_in,
   output logic debug_clock_output,
   output logic debug_clock_output_oe,
   output logic gen_ref_clk,
   output logic rtc_clk,
   output logic pll_bypass,
   output logic [DIV_W-1:0] spi_clk_div,
   output logic [DIV_W-1:0] i2c_clk_div,
   output logic [SLEW_W-1:0] output_slew_rate_control
);

   // Dividers round up so the boot rates are never exceeded
   localparam logic [DIV_W-1:0] SPI_DIV =
      DIV_W'((BOOT_REF_HZ + SPI_RATE_HZ - 1) / SPI_RATE_HZ);
   localparam logic [DIV_W-1:0] I2C_DIV =
      DIV_W'((BOOT_REF_HZ + I2C_RATE_HZ - 1) / I2C_RATE_HZ);

   typedef struct packed {
      cssao_boot_type boot;
      logic [4:0] cnt;
      logic [1:0] src;
      logic dbg_off;
      logic [SLEW_W-1:0] slew;
      logic strap;
      logic bypass;
      logic [DIV_W-1:0] spi_div;
      logic [DIV_W-1:0] i2c_div;
      logic pready;
      logic pslverr;
      logic [DATA_W-1:0] prdata;
      logic dbg_out;
      logic dbg_oe;
      logic gen_ref;
      logic rtc;
   } cssao_state_type;

   localparam cssao_state_type STATE_RST = '{
      boot: BOOT_WAIT, cnt: 5'h00, src: SRC_RST, dbg_off: DBG_OFF_RST,
      slew: SLEW_RST, strap: 1'b0, bypass: 1'b0, spi_div: DIV_RST,
      i2c_div: DIV_RST, pready: 1'b0, pslverr: 1'b0, prdata: 32'h00000000,
      dbg_out: 1'b0, dbg_oe: 1'b1, gen_ref: 1'b0, rtc: 1'b0};

   // Address decode shared by read mux and write strobes
   function automatic logic reg_hit(input logic [ADDR_W-1:0] addr, input logic [15:0] idx);
      reg_hit = (addr == {idx[13:0], 2'b00});
   endfunction

   cssao_state_type r_reg;
   cssao_state_type r_next;
   cssao_clk_in_type pin_s;
   logic sel_val;
   logic apb_setup;
   logic apb_access;
   logic mapped;

   // Every pin, including the strap, is resynchronised before use
   cssao_sync #(
      .W($bits(cssao_clk_in_type))
   ) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(clk_in),
      .q(pin_s)
   );

   // Tap mux for the debug pin; taps faster than pclk/2 alias, debug use only
   always_comb begin
      unique case (r_reg.src)
         SRC_SYSCLK: sel_val = pin_s.sys_clk;
         SRC_PLL: sel_val = pin_s.pll_out;
         SRC_REF: sel_val = r_reg.gen_ref;
         SRC_OSC: sel_val = pin_s.osc_32k;
      endcase
   end

   assign apb_setup = apb_req.psel & ~apb_req.penable;
   assign apb_access = apb_req.psel & apb_req.penable & r_reg.pready;
   assign mapped = reg_hit(apb_req.paddr, REG_IDX_SLEW) | reg_hit(apb_req.paddr, REG_IDX_SRC)
      | reg_hit(apb_req.paddr, REG_IDX_STAT3) | reg_hit(apb_req.paddr, REG_IDX_BOOT);

   // Next state: bus slave, boot sequence, clock routing
   always_comb begin
      r_next = r_reg;
      // Ready one cycle after setup: fixed single wait-free access phase
      r_next.pready = apb_setup;
      if (apb_setup) begin
         r_next.pslverr = ~mapped;
         r_next.prdata = 32'h00000000;
         if (reg_hit(apb_req.paddr, REG_IDX_SLEW)) begin
            r_next.prdata[SLEW_W-1:0] = r_reg.slew;
         end
         if (reg_hit(apb_req.paddr, REG_IDX_SRC)) begin
            r_next.prdata[SRC_LSB +: SRC_W] = r_reg.src;
         end
         if (reg_hit(apb_req.paddr, REG_IDX_STAT3)) begin
            r_next.prdata[DBG_OFF_BIT] = r_reg.dbg_off;
         end
         if (reg_hit(apb_req.paddr, REG_IDX_BOOT)) begin
            r_next.prdata[BOOT_STRAP_BIT] = r_reg.strap;
            r_next.prdata[BOOT_BYPASS_BIT] = r_reg.bypass;
            r_next.prdata[BOOT_DONE_BIT] = (r_reg.boot == BOOT_DONE);
            r_next.prdata[BOOT_OE_BIT] = r_reg.dbg_oe;
            r_next.prdata[SPI_DIV_LSB +: DIV_W] = r_reg.spi_div;
            r_next.prdata[I2C_DIV_LSB +: DIV_W] = r_reg.i2c_div;
         end
      end
      // Software writes take effect only at the completing edge
      if (apb_access && apb_req.pwrite) begin
         if (reg_hit(apb_req.paddr, REG_IDX_SLEW)) begin
            r_next.slew = apb_req.pwdata[SLEW_W-1:0];
         end
         if (reg_hit(apb_req.paddr, REG_IDX_SRC)) begin
            r_next.src = apb_req.pwdata[SRC_LSB +: SRC_W]; // see RULE1
         end
         if (reg_hit(apb_req.paddr, REG_IDX_STAT3)) begin
            r_next.dbg_off = apb_req.pwdata[DBG_OFF_BIT]; // see RULE2
         end
      end
      // Boot sequence comes after the bus so its clock-off set wins a same-cycle clear
      unique case (r_reg.boot)
         BOOT_WAIT: begin
            if (r_reg.cnt == BOOT_START_CYCLES - 5'h01) begin
               r_next.boot = BOOT_START;
            end else begin
               r_next.cnt = r_reg.cnt + 5'h01;
            end
         end
         BOOT_START: begin
            r_next.dbg_off = 1'b1; // see RULE3
            // Strap is caught once; it is assumed never to move afterwards
            r_next.strap = pin_s.strap; // see RULE6
            r_next.bypass = pin_s.strap; // see RULE7
            if (pin_s.strap) begin
               r_next.spi_div = SPI_DIV; // see RULE8
               r_next.i2c_div = I2C_DIV; // see RULE8
            end
            r_next.boot = BOOT_DONE;
         end
         BOOT_DONE: begin
            r_next.boot = BOOT_DONE;
         end
         default: begin
            r_next.boot = BOOT_DONE;
         end
      endcase
      // Clock routing; external input unused while strap is low
      r_next.gen_ref = r_reg.strap ? pin_s.ext_ref : pin_s.osc_32k; // see RULE4 see RULE5
      r_next.rtc = pin_s.osc_32k; // see RULE5
      r_next.dbg_out = sel_val; // see RULE1
      r_next.dbg_oe = ~r_reg.dbg_off; // see RULE2
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= STATE_RST;
      end else begin
         r_reg <= r_next;
      end
   end

   // All outputs straight from the state register
   assign prdata = r_reg.prdata;
   assign pready = r_reg.pready;
   assign pslverr = r_reg.pslverr;
   assign debug_clock_output = r_reg.dbg_out;
   assign debug_clock_output_oe = r_reg.dbg_oe;
   assign gen_ref_clk = r_reg.gen_ref;
   assign rtc_clk = r_reg.rtc;
   assign pll_bypass = r_reg.bypass;
   assign spi_clk_div = r_reg.spi_div;
   assign i2c_clk_div = r_reg.i2c_div;
   assign output_slew_rate_control = r_reg.slew;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   sequence s_boot_start;
      r_reg.boot == BOOT_START;
   endsequence

   sequence s_boot_done_ext;
      r_reg.boot == BOOT_DONE && r_reg.strap;
   endsequence

   a_dbg_src_tap: assert property (1'b1 |=> debug_clock_output == $past(sel_val)) // see RULE1
      else $error("debug output does not follow selected tap");
   a_dbg_off_hiz: assert property (r_reg.dbg_off |=> !debug_clock_output_oe) // see RULE2
      else $error("debug output driven while clock-off set");
   a_reset_drive: assert property (r_reg.boot == BOOT_WAIT && !r_reg.dbg_off |=> // see RULE3
      debug_clock_output_oe)
      else $error("debug output not driven before boot");
   a_boot_dbg_off: assert property (s_boot_start |=> r_reg.dbg_off ##1 // see RULE3
      !debug_clock_output_oe)
      else $error("boot did not turn debug output off");
   a_ref_from_osc: assert property (!r_reg.strap |=> // see RULE4
      gen_ref_clk == $past(pin_s.osc_32k))
      else $error("generator reference not from oscillator");
   a_ref_from_ext: assert property (r_reg.strap |=> // see RULE5
      gen_ref_clk == $past(pin_s.ext_ref))
      else $error("generator reference not from external input");
   a_boot_bypass: assert property (s_boot_start |=> pll_bypass == $past(pin_s.strap)) // see RULE7
      else $error("PLL bypass does not match strap at boot");
   a_boot_divs: assert property (s_boot_done_ext |-> // see RULE8
      spi_clk_div == SPI_DIV && i2c_clk_div == I2C_DIV)
      else $error("boot serial dividers wrong");
   a_apb_ready: assert property (apb_setup |=> pready ##1 !pready)
      else $error("APB ready timing wrong");

endmodule // cssao_top

// ### include/cssao_pkg.sv
// Shared constants and types for the clock source select and debug output block
package cssao_pkg;

   // Bus geometry
   localparam int ADDR_W = 16;
   localparam int DATA_W = 32;

   // Register indices; byte address is four times the index
   localparam logic [15:0] REG_IDX_SLEW = 16'h1C16;
   localparam logic [15:0] REG_IDX_SRC = 16'h1C24;
   localparam logic [15:0] REG_IDX_STAT3 = 16'h1C25;
   localparam logic [15:0] REG_IDX_BOOT = 16'h1C26;

   // Field positions and widths
   localparam int SRC_LSB = 0;
   localparam int SRC_W = 2;
   localparam int DBG_OFF_BIT = 0;
   localparam int BOOT_STRAP_BIT = 0;
   localparam int BOOT_BYPASS_BIT = 1;
   localparam int BOOT_DONE_BIT = 2;
   localparam int BOOT_OE_BIT = 3;
   localparam int SPI_DIV_LSB = 16;
   localparam int I2C_DIV_LSB = 24;
   localparam int DIV_W = 8;
   localparam int SLEW_W = 16;

   // Reset values
   localparam logic [1:0] SRC_RST = 2'h0;
   localparam logic DBG_OFF_RST = 1'b0;
   localparam logic [15:0] SLEW_RST = 16'h0000;
   localparam logic [7:0] DIV_RST = 8'h01;

   // Debug output source codes
   localparam logic [1:0] SRC_SYSCLK = 2'h0;
   localparam logic [1:0] SRC_PLL = 2'h1;
   localparam logic [1:0] SRC_REF = 2'h2;
   localparam logic [1:0] SRC_OSC = 2'h3;

   // Boot timing and assumed boot reference rates
   localparam logic [4:0] BOOT_START_CYCLES = 5'h10;
   localparam int BOOT_REF_11M_HZ = 11_289_600;
   localparam int BOOT_REF_12M_HZ = 12_000_000;
   localparam int BOOT_REF_12M288_HZ = 12_288_000;
   localparam int SPI_RATE_HZ = 500_000;
   localparam int I2C_RATE_HZ = 400_000;

   // Boot sequence states
   typedef enum logic [1:0] {BOOT_WAIT, BOOT_START, BOOT_DONE} cssao_boot_type;

   // APB request as seen by the slave
   typedef struct packed {
      logic psel;
      logic penable;
      logic pwrite;
      logic [ADDR_W-1:0] paddr;
      logic [DATA_W-1:0] pwdata;
   } cssao_apb_req_type;

   // Clock taps and strap arriving from outside the pclk domain
   typedef struct packed {
      logic strap;
      logic osc_32k;
      logic ext_ref;
      logic pll_out;
      logic sys_clk;
   } cssao_clk_in_type;

endpackage

// ### verilog/cssao_sync.sv
// Two-stage synchroniser for pins entering the pclk domain
`timescale 1ns/1ps
module cssao_sync #(
   parameter int W = 1
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   typedef struct packed {
      logic [W-1:0] stage1;
      logic [W-1:0] stage2;
   } cssao_sync_state_type;

   cssao_sync_state_type r_reg;
   cssao_sync_state_type r_next;

   // First stage feeds only the second stage
   always_comb begin
      r_next = r_reg;
      r_next.stage1 = d;
      r_next.stage2 = r_reg.stage1;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign q = r_reg.stage2;

endmodule // cssao_sync

// ### tb/cssao_board_model.sv
// Board-side model: clock-source strap and free-running clock taps
`timescale 1ns/1ps
module cssao_board_model
   import cssao_pkg::*;
(
   input wire logic strap_sel,
   output cssao_clk_in_type clk_in
);
   logic s_clk = 1'b0;
   logic p_clk = 1'b0;
   logic e_clk = 1'b0;
   logic o_clk = 1'b0;
   // Distinct slow half periods so each tap is told apart on the debug pin
   always #120 s_clk = ~s_clk;
   always #136 p_clk = ~p_clk;
   always #152 e_clk = ~e_clk;
   always #200 o_clk = ~o_clk;
   // Strap changes only while the bench holds reset; the reference keeps running
   // even with the strap low so that ignoring it is really exercised
   assign clk_in = '{strap: strap_sel, osc_32k: o_clk, ext_ref: e_clk,
                     pll_out: p_clk, sys_clk: s_clk};
endmodule // cssao_board_model

// ### tb/tb.sv
// Self-checking bench for the clock source select and debug output block
`timescale 1ns/1ps
module tb;
   import cssao_pkg::*;
   localparam int REF_HZ = BOOT_REF_11M_HZ;
   logic pclk, presetn, strap_sel, pready, pslverr, err, dbg, dbg_oe, gen_ref, rtc, bypass;
   cssao_apb_req_type req;
   logic [DATA_W-1:0] prdata, rd, exp_slew;
   logic [DIV_W-1:0] spi_div, i2c_div;
   logic [SLEW_W-1:0] slew;
   cssao_clk_in_type clk_in;
   int fail_count = 0, n_compared = 0, seed = 97877, exp_spi, exp_i2c;
   // Register model: expected read-back words queued at each source and slew write
   logic [31:0] exp_q[$];
   cssao_board_model i_board (.strap_sel(strap_sel), .clk_in(clk_in));
   cssao_top #(.BOOT_REF_HZ(REF_HZ)) i_dut (.pclk(pclk), .presetn(presetn), .apb_req(req),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .clk_in(clk_in),
      .debug_clock_output(dbg), .debug_clock_output_oe(dbg_oe), .gen_ref_clk(gen_ref),
      .rtc_clk(rtc), .pll_bypass(bypass), .spi_clk_div(spi_div), .i2c_clk_div(i2c_div),
      .output_slew_rate_control(slew));
   // Compare and count
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic test_done();
      if (fail_count == 0 && n_compared > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // One APB transfer; request held until pready is seen high at an edge, data taken there
   // An idle cycle first keeps two calls from driving psel twice in one step
   task automatic apb(input logic wr, input logic [15:0] idx, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge pclk);
      req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: idx << 2, pwdata: wd};
      @(posedge pclk);
      req.penable <= 1'b1;
      do begin
         @(posedge pclk);
         if (n++ == 20) begin
            chk("pready wait", 32'h0, 32'h1);
            test_done();
         end
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      req.psel <= 1'b0;
      req.penable <= 1'b0;
   endtask
   // Expected tap per selector; 4 is the generator reference, 5 the timer clock
   function automatic logic tap(input int sel);
      case (sel)
         0: return clk_in.sys_clk;
         1: return clk_in.pll_out;
         2, 4: return strap_sel ? clk_in.ext_ref : clk_in.osc_32k;
         default: return clk_in.osc_32k;
      endcase
   endfunction
   // Wait for a tap edge, let the synchronisers settle, then compare
   task automatic tap_chk(input int sel);
      logic v;
      int n;
      v = tap(sel);
      n = 0;
      while (tap(sel) === v) begin
         if (n++ == 100) begin
            chk("tap edge wait", 32'h0, 32'h1);
            test_done();
         end
         @(posedge pclk);
      end
      repeat (6) @(posedge pclk);
      #1;
      chk("clock tap", (sel == 4) ? gen_ref : (sel == 5) ? rtc : dbg, tap(sel));
   endtask
   // Reset with a new strap, then follow boot to its end
   task automatic boot(input logic s);
      int n;
      n = 0;
      @(posedge pclk);
      presetn <= 1'b0;
      strap_sel <= s;
      repeat (10) @(posedge pclk);
      #1;
      chk("oe in reset", dbg_oe, 32'h1);
      chk("spi div in reset", spi_div, 32'h1);
      @(posedge pclk);
      presetn <= 1'b1;
      #1;
      while (dbg_oe !== 1'b0) begin
         if (n++ == 40) begin
            chk("boot wait", 32'h0, 32'h1);
            test_done();
         end
         @(posedge pclk);
         #1;
      end
      chk("oe held before boot", 32'(n >= 16), 32'h1);
      exp_spi = s ? (REF_HZ + SPI_RATE_HZ - 1) / SPI_RATE_HZ : 1;
      exp_i2c = s ? (REF_HZ + I2C_RATE_HZ - 1) / I2C_RATE_HZ : 1;
      chk("bypass", bypass, 32'(s));
      chk("divs", {spi_div, i2c_div}, 32'(exp_spi * 256 + exp_i2c));
      apb(1'b0, REG_IDX_BOOT, 32'h0);
      chk("boot status", rd, 32'(exp_i2c << 24 | exp_spi << 16 | 4 | s << 1 | s));
   endtask
   initial begin
      pclk = 1'b0;
      forever #4 pclk = ~pclk;
   end
   // Main sequence: strap high first, then low
   initial begin
      presetn = 1'b0;
      strap_sel = 1'b1;
      req = '0;
      for (int s = 1; s >= 0; s--) begin
         boot(s[0]);
         apb(1'b1, REG_IDX_STAT3, 32'h0);
         repeat (2) @(posedge pclk);
         #1;
         chk("oe on", dbg_oe, 32'h1);
         for (int c = 0; c < 4; c++) begin
            // Random upper bits must not stick: only the select field reads back
            apb(1'b1, REG_IDX_SRC, ($random(seed) & 32'hFFFFFFFC) | 32'(c));
            exp_q.push_back(32'(c));
            apb(1'b0, REG_IDX_SRC, 32'h0);
            chk("source field", rd, exp_q.pop_front());
            tap_chk(c);
         end
         tap_chk(4);
         tap_chk(5);
         apb(1'b1, REG_IDX_STAT3, 32'h1);
         repeat (2) @(posedge pclk);
         #1;
         chk("oe off", dbg_oe, 32'h0);
         apb(1'b0, 16'h1C30, 32'h0);
         chk("unmapped", {rd[30:0], err}, 32'h1);
         exp_slew = $random(seed) & 32'h0000FFFF;
         apb(1'b1, REG_IDX_SLEW, exp_slew);
         exp_q.push_back(exp_slew);
         apb(1'b0, REG_IDX_SLEW, 32'h0);
         chk("slew", rd, exp_q.pop_front());
         chk("slew port", slew, exp_slew);
      end
      test_done();
   end
endmodule // tb
